/* common/scad_params.svh */
// Constants for the strap configuration decoder: codes, bases, timing.
// Assumes the pin front end reports one six-bit code per pin.
`ifndef SCAD_PARAMS_SVH
`define SCAD_PARAMS_SVH

// ==========================================================
// Pin codes: three straps, then one code per resistor step
`define SCAD_CODE_LOW 6'h00
`define SCAD_CODE_OPEN 6'h01
`define SCAD_CODE_HIGH 6'h02
`define SCAD_CODE_RES_BASE 6'h03
`define SCAD_CODE_RES_LAST 6'h21
`define SCAD_VOUT_CODE_LAST 6'h20

// ==========================================================
// Pin positions in the pin array
`define SCAD_NUM_PINS 5
`define SCAD_PIN_MODE 0
`define SCAD_PIN_ADDR 1
`define SCAD_PIN_SYNC 2
`define SCAD_PIN_SS 3
`define SCAD_PIN_VOUT 4

// ==========================================================
// Mode, address and role decode
`define SCAD_CS_MIN_IDX 5'h10
`define SCAD_CS3_MIN_IDX 5'h19
`define SCAD_CS2_IDX_LIMIT 5'h10
`define SCAD_CS3_IDX_LIMIT 5'h0F
`define SCAD_ADDR_STRAP_BASE 7'h23
`define SCAD_ADDR_RES_BASE 7'h50
`define SCAD_PHASE_FULL 5'h10

// ==========================================================
// Output voltage scaling and timing
`define SCAD_VOUT_LSB_MV 10
`define SCAD_VMAX_PCT 110
`define SCAD_MEMCHK_TIME_US 5000
`define SCAD_CLK_MHZ 50

`endif

/* common/scad_pkg.sv */
// Types shared by the strap configuration decoder.
// Assumes scad_params.svh supplies the numeric constants.
package scad_pkg;
   typedef logic [5:0] scad_code_t;
   typedef enum logic [1:0] {SCAD_CMD_RELOAD, SCAD_CMD_PHASE, SCAD_CMD_VOUT,
      SCAD_CMD_CLR_ALERT} scad_cmd_t;
   typedef enum logic [1:0] {ST_CHECK, ST_LOAD, ST_READY} scad_state_t;
endpackage

/* hdl/scad_top.sv */
// Strap configuration decoder: samples five multi-mode pins and derives
// address, mode, role, voltage limit and phase offset.
// Assumes pin codes come from a measurement front end (asynchronous) and
// host commands arrive on the link clock from the serial interface.
//
// Contract
// - Sample pins at power-up and reload only
// - Decode strap states or 31 resistor selections
// - One code per recognised resistor step
// - Exactly five configuration pins
// - Unused pins fall back to defaults
// - Address pin sets address, phase, role
// - Eight two-phase or five three-phase groups
// - Mode pin chooses single or shared mode
// - Mode pin also selects compensation, sync
// - Sync pin ignored in current-sharing mode
// - Soft-start and voltage pins mode independent
// - Separate alert line signals faults
// - Voltage ceiling ten percent above pin voltage
// - Link works at 100k and 400k
// - Strap address gives 0x23, 0x24, 0x25
// - Resistor address runs 0x50 to 0x6E
// - Spreading needs a shared sync clock
// - Standalone phase is address times 45 degrees
// - Bus sets phase in 22.5 degree steps
// - Ignore commands during memory check and load
// - Latched pin values hold while ready; a reload command resamples them
`include "scad_params.svh"
`timescale 1ns/10ps
`default_nettype none

module scad_top #(
   parameter int MEMCHK_CYCLES = `SCAD_MEMCHK_TIME_US * `SCAD_CLK_MHZ
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic link_clk,
   input wire scad_pkg::scad_code_t mode_select_pin,
   input wire scad_pkg::scad_code_t address_strap_pin,
   input wire scad_pkg::scad_code_t sync_pin,
   input wire scad_pkg::scad_code_t softstart_pin,
   input wire scad_pkg::scad_code_t vout_set_pin,
   input wire logic fault_in,
   input wire logic link_cmd_valid,
   input wire scad_pkg::scad_cmd_t link_cmd_kind,
   input wire logic [11:0] link_cmd_data,
   output logic link_ready,
   output logic [6:0] link_address,
   output logic config_ready,
   output logic [6:0] bus_address,
   output logic current_share,
   output logic cs_three_phase,
   output logic cs_reference,
   output logic [2:0] cs_group,
   output logic [1:0] cs_position,
   output scad_pkg::scad_code_t mode_sel_code,
   output scad_pkg::scad_code_t sync_sel_code,
   output scad_pkg::scad_code_t softstart_sel_code,
   output scad_pkg::scad_code_t vout_sel_code,
   output logic [11:0] vout_target_mv,
   output logic [11:0] vout_max_mv,
   output logic phase_spread_en,
   output logic [4:0] phase_units,
   output logic fault_alert_line_o,
   output logic fault_alert_line_oe
);
   import scad_pkg::*;

   localparam int TW = $clog2(MEMCHK_CYCLES + 1);
   localparam int NP = `SCAD_NUM_PINS;

   // Output voltage per pin code, in 10 mV units; straps first
   localparam logic [8:0] VOUT_TBL [0:32] = '{
      9'h078, 9'h096, 9'h14A, 9'h03C, 9'h041, 9'h046, 9'h04B, 9'h050, 9'h055,
      9'h05A, 9'h05F, 9'h064, 9'h069, 9'h06E, 9'h073, 9'h078, 9'h07D, 9'h082,
      9'h08C, 9'h096, 9'h0A0, 9'h0AA, 9'h0B4, 9'h0BE, 9'h0C8, 9'h0D2, 9'h0DC,
      9'h0E6, 9'h0FA, 9'h118, 9'h12C, 9'h14A, 9'h168};

   // Unrecognised codes read as an open pin
   function automatic scad_code_t code_norm(input scad_code_t c);
      code_norm = (c > `SCAD_CODE_RES_LAST) ? `SCAD_CODE_OPEN : c;
   endfunction

   // ==========================================================
   // Pin synchronisers and latches
   scad_state_t state_r;
   scad_state_t state_nxt;
   scad_code_t pin_raw [NP];
   scad_code_t pin_s1_r [NP];
   scad_code_t pin_s2_r [NP];
   scad_code_t code_lat_r [NP];
   scad_code_t n_code [NP];

   assign pin_raw[`SCAD_PIN_MODE] = mode_select_pin;
   assign pin_raw[`SCAD_PIN_ADDR] = address_strap_pin;
   assign pin_raw[`SCAD_PIN_SYNC] = sync_pin;
   assign pin_raw[`SCAD_PIN_SS] = softstart_pin;
   assign pin_raw[`SCAD_PIN_VOUT] = vout_set_pin;

   // Two flops per pin; codes are latched only in the load state
   for (genvar g = 0; g < NP; g++) begin : g_pin
      assign n_code[g] = code_norm(pin_s2_r[g]);
      always_ff @(posedge mclk or posedge reset) begin
         if (reset) begin
            pin_s1_r[g] <= `SCAD_CODE_OPEN;
            pin_s2_r[g] <= `SCAD_CODE_OPEN;
            code_lat_r[g] <= `SCAD_CODE_OPEN;
         end else begin
            pin_s1_r[g] <= pin_raw[g];
            pin_s2_r[g] <= pin_s1_r[g];
            if (state_r == ST_LOAD) begin
               code_lat_r[g] <= n_code[g];
            end
         end
      end
   end

   // ==========================================================
   // Decode of the synchronised codes
   wire logic mode_res = n_code[`SCAD_PIN_MODE] >= `SCAD_CODE_RES_BASE;
   wire logic [4:0] mode_idx = 5'(n_code[`SCAD_PIN_MODE] - `SCAD_CODE_RES_BASE);
   wire logic addr_res = n_code[`SCAD_PIN_ADDR] >= `SCAD_CODE_RES_BASE;
   wire logic [4:0] addr_idx = 5'(n_code[`SCAD_PIN_ADDR] - `SCAD_CODE_RES_BASE);
   wire logic [6:0] strap_addr = `SCAD_ADDR_STRAP_BASE + 7'(n_code[`SCAD_PIN_ADDR]);
   wire logic [6:0] res_addr = `SCAD_ADDR_RES_BASE + 7'(addr_idx);

   // Mode from the mode pin; mode_idx 16 and up shares current, 25 and up in three phases
   wire logic cs_nxt = mode_res && (mode_idx >= `SCAD_CS_MIN_IDX);
   wire logic cs3_nxt = cs_nxt && (mode_idx >= `SCAD_CS3_MIN_IDX);
   wire logic [6:0] addr_nxt = addr_res ? res_addr : strap_addr;

   // Role: group and position in group from the address step
   wire logic role2_ok = addr_res && (addr_idx < `SCAD_CS2_IDX_LIMIT);
   wire logic role3_ok = addr_res && (addr_idx <= `SCAD_CS3_IDX_LIMIT) &&
      (addr_idx != `SCAD_CS3_IDX_LIMIT);
   wire logic [2:0] grp2 = addr_idx[3:1];
   wire logic [2:0] grp3 = 3'(addr_idx / 5'h03);
   wire logic [1:0] pos2 = {1'b0, addr_idx[0]};
   wire logic [1:0] pos3 = 2'(addr_idx % 5'h03);
   wire logic [2:0] grp_nxt = !cs_nxt ? 3'h0 : cs3_nxt ? (role3_ok ? grp3 : 3'h0) :
      (role2_ok ? grp2 : 3'h0);
   wire logic [1:0] pos_nxt = !cs_nxt ? 2'h0 : cs3_nxt ? (role3_ok ? pos3 : 2'h0) :
      (role2_ok ? pos2 : 2'h0);

   // Sync input only counts alone; tied group pins make it moot
   wire scad_code_t sync_nxt = cs_nxt ? `SCAD_CODE_OPEN : n_code[`SCAD_PIN_SYNC];
   wire logic spread_nxt = cs_nxt || (n_code[`SCAD_PIN_MODE] == `SCAD_CODE_HIGH);
   wire logic [4:0] phase_addr = {1'b0, addr_nxt[2:0], 1'b0};

   // Voltage and ceiling; the top resistor step has no voltage entry
   wire scad_code_t vcode = (n_code[`SCAD_PIN_VOUT] > `SCAD_VOUT_CODE_LAST) ?
      `SCAD_CODE_OPEN : n_code[`SCAD_PIN_VOUT];
   wire logic [8:0] vtbl = VOUT_TBL[vcode];
   wire logic [11:0] vout_nxt = 12'(32'(vtbl) * `SCAD_VOUT_LSB_MV);
   wire logic [11:0] vmax_nxt = 12'(32'(vtbl) * `SCAD_VOUT_LSB_MV * `SCAD_VMAX_PCT / 100);

   // ==========================================================
   // Link domain: commands captured and handed over by toggle
   logic rdy_s1_r;
   logic rdy_s2_r;
   logic lk_tog_r;
   scad_cmd_t lk_kind_r;
   logic [11:0] lk_data_r;
   logic link_ready_r;
   logic [6:0] link_address_r;
   logic config_ready_r;
   logic [6:0] bus_address_r;

   wire logic lk_accept = link_cmd_valid && rdy_s2_r;

   // Link logic: serial rate only sets how often commands come
   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         rdy_s1_r <= 1'b0;
         rdy_s2_r <= 1'b0;
         lk_tog_r <= 1'b0;
         lk_kind_r <= SCAD_CMD_RELOAD;
         lk_data_r <= 12'h000;
         link_ready_r <= 1'b0;
         link_address_r <= 7'h00;
      end else begin
         rdy_s1_r <= config_ready_r;
         rdy_s2_r <= rdy_s1_r;
         link_ready_r <= rdy_s2_r;
         if (rdy_s2_r) begin
            link_address_r <= bus_address_r;
         end
         if (lk_accept) begin
            lk_tog_r <= ~lk_tog_r;
            lk_kind_r <= link_cmd_kind;
            lk_data_r <= link_cmd_data;
         end
      end
   end

   // ==========================================================
   // Main domain: toggle receive and start-up sequence
   logic tog_s1_r;
   logic tog_s2_r;
   logic tog_s3_r;
   logic [TW-1:0] timer_r;

   // Kind and data are held for the host command spacing, so stable here
   wire logic cmd_hit = (tog_s2_r ^ tog_s3_r) && (state_r == ST_READY);
   wire logic hit_reload = cmd_hit && (lk_kind_r == SCAD_CMD_RELOAD);
   wire logic hit_phase = cmd_hit && (lk_kind_r == SCAD_CMD_PHASE);
   wire logic hit_vout = cmd_hit && (lk_kind_r == SCAD_CMD_VOUT);
   wire logic hit_clr = cmd_hit && (lk_kind_r == SCAD_CMD_CLR_ALERT);
   wire logic [4:0] phase_cmd = (lk_data_r > 12'(`SCAD_PHASE_FULL)) ?
      `SCAD_PHASE_FULL : lk_data_r[4:0];
   wire logic [11:0] vout_cmd = (lk_data_r > vout_max_mv) ? vout_max_mv : lk_data_r;

   // Next state: check, load once, then wait for a reload
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_CHECK: begin
            if (timer_r == '0) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_nxt = ST_READY;
         end
         ST_READY: begin
            if (hit_reload) begin
               state_nxt = ST_CHECK;
            end
         end
         default: begin
            state_nxt = ST_CHECK;
         end
      endcase
   end

   // State, memory-check timer and toggle synchroniser
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= ST_CHECK;
         timer_r <= TW'(MEMCHK_CYCLES - 1);
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tog_s1_r <= lk_tog_r;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         if (state_nxt == ST_CHECK && state_r != ST_CHECK) begin
            timer_r <= TW'(MEMCHK_CYCLES - 1);
         end else if (state_r == ST_CHECK && timer_r != '0) begin
            timer_r <= timer_r - 1'b1;
         end
      end
   end

   // ==========================================================
   // Configuration outputs
   logic current_share_r;
   logic cs_three_r;
   logic cs_reference_r;
   logic [2:0] cs_group_r;
   logic [1:0] cs_position_r;
   scad_code_t sync_sel_r;
   logic [11:0] vout_target_r;
   logic [11:0] vout_max_r;
   logic spread_r;
   logic [4:0] phase_r;
   logic alert_r;

   // Loaded in one go; bus writes only touch phase and voltage
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_ready_r <= 1'b0;
         bus_address_r <= 7'h00;
         current_share_r <= 1'b0;
         cs_three_r <= 1'b0;
         cs_reference_r <= 1'b0;
         cs_group_r <= 3'h0;
         cs_position_r <= 2'h0;
         sync_sel_r <= `SCAD_CODE_OPEN;
         vout_target_r <= 12'h000;
         vout_max_r <= 12'h000;
         spread_r <= 1'b0;
         phase_r <= 5'h00;
      end else begin
         config_ready_r <= (state_nxt == ST_READY);
         if (state_r == ST_LOAD) begin
            bus_address_r <= addr_nxt;
            current_share_r <= cs_nxt;
            cs_three_r <= cs3_nxt;
            cs_reference_r <= (pos_nxt == 2'h0);
            cs_group_r <= grp_nxt;
            cs_position_r <= pos_nxt;
            sync_sel_r <= sync_nxt;
            vout_target_r <= vout_nxt;
            vout_max_r <= vmax_nxt;
            spread_r <= spread_nxt;
            phase_r <= spread_nxt ? phase_addr : 5'h00;
         end else begin
            if (hit_phase) begin
               phase_r <= spread_r ? phase_cmd : 5'h00;
            end
            if (hit_vout) begin
               vout_target_r <= vout_cmd;
            end
         end
      end
   end

   // Sticky alert; a fault in the clearing cycle keeps it set
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         alert_r <= 1'b0;
      end else begin
         alert_r <= fault_in || (alert_r && !hit_clr);
      end
   end

   assign link_ready = link_ready_r;
   assign link_address = link_address_r;
   assign config_ready = config_ready_r;
   assign bus_address = bus_address_r;
   assign current_share = current_share_r;
   assign cs_three_phase = cs_three_r;
   assign cs_reference = cs_reference_r;
   assign cs_group = cs_group_r;
   assign cs_position = cs_position_r;
   assign mode_sel_code = code_lat_r[`SCAD_PIN_MODE];
   assign sync_sel_code = sync_sel_r;
   assign softstart_sel_code = code_lat_r[`SCAD_PIN_SS];
   assign vout_sel_code = code_lat_r[`SCAD_PIN_VOUT];
   assign vout_target_mv = vout_target_r;
   assign vout_max_mv = vout_max_r;
   assign phase_spread_en = spread_r;
   assign phase_units = phase_r;
   assign fault_alert_line_o = 1'b0; // Open drain: pulls low only
   assign fault_alert_line_oe = alert_r;

   // ==========================================================
   // Assertions
   AST_NO_RESAMPLE: assert property (@(posedge mclk) disable iff (reset)
      config_ready_r ##1 config_ready_r |-> $stable(bus_address_r) && $stable(vout_max_r))
      else $error("configuration changed while ready");
   AST_RELOAD_DROPS: assert property (@(posedge mclk) disable iff (reset)
      hit_reload |=> !config_ready_r [*3])
      else $error("reload did not restart the check");
   AST_STRAP_ADDR: assert property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) && code_lat_r[`SCAD_PIN_ADDR] < `SCAD_CODE_RES_BASE |->
      bus_address_r == 7'h23 + 7'(code_lat_r[`SCAD_PIN_ADDR]))
      else $error("strap address wrong");
   AST_RES_ADDR: assert property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) && code_lat_r[`SCAD_PIN_ADDR] >= `SCAD_CODE_RES_BASE |->
      bus_address_r == 7'h4D + 7'(code_lat_r[`SCAD_PIN_ADDR]))
      else $error("resistor address wrong");
   AST_MODE: assert property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) |-> current_share_r ==
      (code_lat_r[`SCAD_PIN_MODE] >= 6'h13))
      else $error("mode decode wrong");
   AST_SYNC_IGNORED: assert property (@(posedge mclk) disable iff (reset)
      config_ready_r && current_share_r |-> sync_sel_r == `SCAD_CODE_OPEN)
      else $error("sync code used in shared mode");
   AST_VMAX: assert property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) |-> 32'(vout_max_r) * 10 == 32'(vout_target_r) * 11)
      else $error("ceiling not ten percent above pin voltage");
   AST_VOUT_CAP: assert property (@(posedge mclk) disable iff (reset)
      config_ready_r |-> vout_target_r <= vout_max_r)
      else $error("voltage above ceiling");
   AST_PHASE_ADDR: assert property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) && spread_r |-> phase_r == {1'b0, bus_address_r[2:0], 1'b0})
      else $error("address phase wrong");
   AST_PHASE_RANGE: assert property (@(posedge mclk) disable iff (reset)
      hit_phase ##1 spread_r |-> phase_r <= 5'h10 && phase_r == $past(phase_cmd))
      else $error("programmed phase wrong");
   AST_LINK_BUSY: assert property (@(posedge link_clk) disable iff (reset)
      link_cmd_valid && !rdy_s2_r |=> $stable(lk_tog_r))
      else $error("command taken while busy");
   AST_ALERT: assert property (@(posedge mclk) disable iff (reset)
      fault_in |=> fault_alert_line_oe ##1 (fault_alert_line_oe || $past(hit_clr)))
      else $error("alert not raised");
   CV_RELOAD: cover property (@(posedge mclk) disable iff (reset)
      hit_reload ##[1:300] !config_ready_r);
   CV_SHARED: cover property (@(posedge mclk) disable iff (reset)
      $rose(config_ready_r) && current_share_r && cs_three_r);
   CV_PHASE: cover property (@(posedge mclk) disable iff (reset) hit_phase && spread_r);
   CV_ALERT_CLR: cover property (@(posedge mclk) disable iff (reset) alert_r && hit_clr);

endmodule

`default_nettype wire

/* sim/scad_host_model.sv */
// Host side of the link: issues single-cycle commands on the link clock.
// Assumes link_clk and link_ready come from the bench and the decoder.
`timescale 1ns/10ps
`default_nettype none

module scad_host_model
   import scad_pkg::*;
#(
   parameter int GAP = 4
) (
   input wire logic link_clk,
   input wire logic link_ready,
   output logic link_cmd_valid,
   output scad_pkg::scad_cmd_t link_cmd_kind,
   output logic [11:0] link_cmd_data
);
   // ==========================================================
   // Idle levels before the first command
   initial begin
      link_cmd_valid = 1'b0;
      link_cmd_kind = SCAD_CMD_CLR_ALERT;
      link_cmd_data = 12'h000;
   end

   // One strobe per command; kind and data stay put afterwards
   task automatic send(input scad_cmd_t kind, input logic [11:0] data, input bit wait_rdy);
      int n;
      n = 0;
      @(posedge link_clk);
      // Bounded wait so a dead ready line cannot hang the host
      while (wait_rdy && link_ready !== 1'b1 && n < 100) begin
         @(posedge link_clk);
         n++;
      end
      link_cmd_valid <= 1'b1;
      link_cmd_kind <= kind;
      link_cmd_data <= data;
      @(posedge link_clk);
      link_cmd_valid <= 1'b0;
      // Quiet gap of GAP link cycles before the next command
      repeat (GAP) @(posedge link_clk);
   endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the strap configuration decoder.
// Assumes a shortened memory check and a host model on the link side.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import scad_pkg::*;
   localparam int MEMCHK = 20;
   logic mclk, reset, link_clk, fault_in;
   scad_code_t mode_pin, addr_pin, sync_pin, ss_pin, vout_pin;
   logic link_cmd_valid, link_ready, config_ready, current_share, cs_three_phase;
   logic cs_reference, phase_spread_en, alert_o, alert_oe;
   scad_cmd_t link_cmd_kind;
   logic [11:0] link_cmd_data, vout_target_mv, vout_max_mv;
   logic [6:0] link_address, bus_address;
   logic [2:0] cs_group;
   logic [1:0] cs_position;
   logic [4:0] phase_units;
   scad_code_t mode_sel_code, sync_sel_code, softstart_sel_code, vout_sel_code;
   int miscompares = 0;
   int check_count = 0;
   // Configuration table: pins in, expected decode out
   scad_code_t t_mode[8] = '{6'h00, 6'h01, 6'h02, 6'h12, 6'h13, 6'h21, 6'h16, 6'h1C};
   scad_code_t t_addr[8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h21, 6'h13, 6'h08, 6'h11};
   scad_code_t t_vout[8] = '{6'h00, 6'h02, 6'h03, 6'h12, 6'h20, 6'h21, 6'h00, 6'h00};
   logic [6:0] e_addr[8] = '{7'h23, 7'h24, 7'h25, 7'h50, 7'h6E, 7'h60, 7'h55, 7'h5E};
   logic [11:0] e_tgt[8] = '{12'h04B0, 12'h0CE4, 12'h0258, 12'h0578, 12'h0E10, 12'h05DC,
      12'h04B0, 12'h04B0};
   logic [11:0] e_max[8] = '{12'h0528, 12'h0E2E, 12'h0294, 12'h0604, 12'h0F78, 12'h0672,
      12'h0528, 12'h0528};
   logic [4:0] e_ph[8] = '{5'h00, 5'h00, 5'h0A, 5'h00, 5'h0C, 5'h00, 5'h0A, 5'h0C};
   logic [2:0] e_grp[8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4};
   logic [1:0] e_pos[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
   logic e_cs[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   logic e_3ph[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

   scad_top #(.MEMCHK_CYCLES(MEMCHK)) dut (.mclk(mclk), .reset(reset), .link_clk(link_clk),
      .mode_select_pin(mode_pin), .address_strap_pin(addr_pin), .sync_pin(sync_pin),
      .softstart_pin(ss_pin), .vout_set_pin(vout_pin), .fault_in(fault_in),
      .link_cmd_valid(link_cmd_valid), .link_cmd_kind(link_cmd_kind),
      .link_cmd_data(link_cmd_data), .link_ready(link_ready), .link_address(link_address),
      .config_ready(config_ready), .bus_address(bus_address), .current_share(current_share),
      .cs_three_phase(cs_three_phase), .cs_reference(cs_reference), .cs_group(cs_group),
      .cs_position(cs_position), .mode_sel_code(mode_sel_code), .sync_sel_code(sync_sel_code),
      .softstart_sel_code(softstart_sel_code), .vout_sel_code(vout_sel_code),
      .vout_target_mv(vout_target_mv), .vout_max_mv(vout_max_mv),
      .phase_spread_en(phase_spread_en), .phase_units(phase_units),
      .fault_alert_line_o(alert_o), .fault_alert_line_oe(alert_oe));

   scad_host_model #(.GAP(4)) host (.link_clk(link_clk), .link_ready(link_ready),
      .link_cmd_valid(link_cmd_valid), .link_cmd_kind(link_cmd_kind),
      .link_cmd_data(link_cmd_data));

   // ==========================================================
   // Clocks: link clock offset so the two never line up
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait on the ready level, sampled away from the edge
   task automatic wait_level(input logic v);
      int n;
      n = 0;
      while (config_ready !== v && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check("config_ready", {15'h0000, config_ready}, {15'h0000, v});
   endtask

   task automatic set_pins(input scad_code_t m, input scad_code_t a, input scad_code_t s,
      input scad_code_t v);
      @(posedge mclk);
      mode_pin <= m;
      addr_pin <= a;
      sync_pin <= s;
      ss_pin <= s;
      vout_pin <= v;
   endtask

   // Command, then enough mclk cycles for the crossing to land
   task automatic cmd(input scad_cmd_t k, input logic [11:0] d);
      host.send(k, d, 1'b1);
      repeat (16) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic complete_run();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, well beyond eight reloads and the command traffic
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      fault_in = 1'b0;
      // Mode pin high keeps every unit on one shared sync clock
      mode_pin = 6'h02;
      addr_pin = 6'h12;
      sync_pin = 6'h05;
      ss_pin = 6'h05;
      vout_pin = 6'h00;
      // Held three cycles; both domains reset asynchronously anyway
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("ready_in_reset", {15'h0000, config_ready}, 16'h0000);
      check("code_in_reset", {10'h000, mode_sel_code}, 16'h0001);
      @(posedge mclk);
      reset <= 1'b0;
      // A phase command during the memory check must be dropped
      host.send(SCAD_CMD_PHASE, 12'h009, 1'b0);
      wait_level(1'b1);
      @(negedge mclk);
      check("phase_addr", {11'h000, phase_units}, 16'h000E);
      check("spread_en", {15'h0000, phase_spread_en}, 16'h0001);
      cmd(SCAD_CMD_PHASE, 12'h006);
      check("phase_prog", {11'h000, phase_units}, 16'h0006);
      cmd(SCAD_CMD_PHASE, 12'h014);
      check("phase_clamp", {11'h000, phase_units}, 16'h0010);
      cmd(SCAD_CMD_VOUT, 12'h04E2);
      check("vout_prog", {4'h0, vout_target_mv}, 16'h04E2);
      cmd(SCAD_CMD_VOUT, 12'h0FA0);
      check("vout_clamp", {4'h0, vout_target_mv}, 16'h0528);
      // Alert raised by a one-cycle fault, then cleared by the host
      @(posedge mclk);
      fault_in <= 1'b1;
      @(posedge mclk);
      fault_in <= 1'b0;
      @(negedge mclk);
      check("alert_oe", {15'h0000, alert_oe}, 16'h0001);
      check("alert_o", {15'h0000, alert_o}, 16'h0000);
      cmd(SCAD_CMD_CLR_ALERT, 12'h000);
      check("alert_clr", {15'h0000, alert_oe}, 16'h0000);
      // Every table row reloaded through the link
      for (int i = 0; i < 8; i++) begin
         set_pins(t_mode[i], t_addr[i], 6'h05, t_vout[i]);
         host.send(SCAD_CMD_RELOAD, 12'h000, 1'b1);
         wait_level(1'b0);
         wait_level(1'b1);
         @(negedge mclk);
         check("bus_address", {9'h000, bus_address}, {9'h000, e_addr[i]});
         check("cs", {15'h0000, current_share}, {15'h0000, e_cs[i]});
         check("cs3", {15'h0000, cs_three_phase}, {15'h0000, e_3ph[i]});
         check("group", {13'h0000, cs_group}, {13'h0000, e_grp[i]});
         check("position", {14'h0000, cs_position}, {14'h0000, e_pos[i]});
         check("sync", {10'h000, sync_sel_code}, e_cs[i] ? 16'h0001 : 16'h0005);
         check("ss", {10'h000, softstart_sel_code}, 16'h0005);
         check("mode", {10'h000, mode_sel_code}, {10'h000, t_mode[i]});
         check("vout", {4'h0, vout_target_mv}, {4'h0, e_tgt[i]});
         check("vout_code", {10'h000, vout_sel_code}, {10'h000, t_vout[i]});
         check("vmax", {4'h0, vout_max_mv}, {4'h0, e_max[i]});
         check("phase", {11'h000, phase_units}, {11'h000, e_ph[i]});
         check("ref", {15'h0000, cs_reference}, {15'h0000, e_pos[i] == 2'h0});
      end
      // Pins moved while ready must leave the latched setup alone
      set_pins(6'h00, 6'h00, 6'h02, 6'h02);
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      check("latched_addr", {9'h000, bus_address}, 16'h005E);
      check("latched_vmax", {4'h0, vout_max_mv}, 16'h0528);
      check("link_ready", {15'h0000, link_ready}, 16'h0001);
      check("link_address", {9'h000, link_address}, 16'h005E);
      complete_run();
   end
endmodule

`default_nettype wire
